/* File: hdl/setpoint_pkg.sv */
// Purpose: shared constants, object addresses and the state record of the set-point block
// Assumes: AHB-Lite word registers; byte address = {index, subindex, 2'b00}
// Notes: gains are unsigned with GAIN_FRAC fraction bits
package setpoint_pkg;

  function automatic logic [25:0] obj_addr(input logic [15:0] idx, input logic [7:0] sub);
    return {idx, sub, 2'b00};
  endfunction

  localparam logic [25:0] ADDR_MODE = obj_addr(16'h6060, 8'h00);
  localparam logic [25:0] ADDR_SRC_COUNT = obj_addr(16'h2331, 8'h00);
  localparam logic [25:0] ADDR_SRC_VOLT = obj_addr(16'h2331, 8'h01);
  localparam logic [25:0] ADDR_SRC_CURR = obj_addr(16'h2331, 8'h02);
  localparam logic [25:0] ADDR_SRC_VEL = obj_addr(16'h2331, 8'h03);
  localparam logic [25:0] ADDR_SRC_POS = obj_addr(16'h2331, 8'h04);
  localparam logic [25:0] ADDR_VREF = obj_addr(16'h2341, 8'h00);
  localparam logic [25:0] ADDR_AN_GAIN = obj_addr(16'h2313, 8'h01);
  localparam logic [25:0] ADDR_AN_OFF = obj_addr(16'h2313, 8'h02);
  localparam logic [25:0] ADDR_MOT_GAIN = obj_addr(16'h2315, 8'h01);
  localparam logic [25:0] ADDR_REF_GAIN = obj_addr(16'h2316, 8'h04);
  localparam logic [25:0] ADDR_PWM_GAIN = obj_addr(16'h2317, 8'h01);
  localparam logic [25:0] ADDR_PWM_OFF = obj_addr(16'h2317, 8'h02);
  localparam logic [25:0] ADDR_STEPS = obj_addr(16'h2329, 8'h01);
  localparam logic [25:0] ADDR_INTERP = obj_addr(16'h2329, 8'h10);
  localparam logic [25:0] ADDR_CTRL = obj_addr(16'h2400, 8'h00);
  localparam logic [25:0] ADDR_VNOM = obj_addr(16'h2400, 8'h01);
  localparam logic [25:0] ADDR_ICONT = obj_addr(16'h2400, 8'h02);
  localparam logic [25:0] ADDR_POS_TGT = obj_addr(16'h2400, 8'h03);
  localparam logic [25:0] ADDR_VOLT_OUT = obj_addr(16'h2400, 8'h04);
  localparam logic [25:0] ADDR_RES = obj_addr(16'h2400, 8'h05);
  localparam logic [25:0] ADDR_REL_CNT = obj_addr(16'h2400, 8'h06);

  localparam logic [7:0] MODE_VOLTAGE = 8'hFF;
  localparam logic [7:0] MODE_EXT_POS = 8'hFE;
  localparam logic [7:0] SRC_ENTRY_COUNT = 8'h04;
  localparam logic [7:0] SRC_NONE = 8'h00;
  localparam logic [7:0] SRC_AN1 = 8'h01;
  localparam logic [7:0] SRC_AN2 = 8'h02;
  localparam logic [7:0] SRC_PWM = 8'h03;
  localparam logic [7:0] SRC_MOT_QUAD = 8'h04;
  localparam logic [7:0] SRC_REF_QUAD = 8'h05;
  localparam logic [7:0] SRC_PULSE_DIR = 8'h09;

  localparam logic [1:0] SYNC_OFF = 2'h0;
  localparam logic [1:0] SYNC_CONST_V = 2'h1;
  localparam logic [1:0] SYNC_CONST_I = 2'h2;

  localparam int GAIN_FRAC = 8;
  localparam logic [15:0] GAIN_RESET = 16'h0100;
  localparam logic [15:0] INTERP_RESET = 16'h0040;
  localparam logic [15:0] STEPS_RESET = 16'h00C8;
  localparam int RES_DIV_SHIFT = 2;
  localparam int ANGLE_STEPS = 64;
  localparam int VOLT_UNIT_MV = 10;

  typedef enum logic [1:0] {
    OPS_IDLE = 2'b00,
    OPS_VOLT = 2'b01,
    OPS_EXTPOS = 2'b11
  } ops_t;

  typedef struct packed {
    logic wr_pend;
    logic [25:0] addr;
    logic [31:0] hrdata;
    logic [7:0] mode_obj;
    ops_t ops;
    logic [2:0] ctrl;
    logic [3:0][7:0] src;
    logic [15:0] vref;
    logic [15:0] an_gain;
    logic [15:0] an_off;
    logic [15:0] pwm_gain;
    logic [15:0] pwm_off;
    logic [15:0] mot_gain;
    logic [15:0] ref_gain;
    logic [15:0] interp;
    logic [15:0] steps;
    logic [15:0] vnom;
    logic [15:0] icont;
    logic [5:0] s1;
    logic [5:0] s2;
    logic [5:0] s3;
    logic [5:0] filt;
    logic [31:0] cnt_mot;
    logic [31:0] cnt_ref;
    logic [31:0] base_pos;
    logic [31:0] pos_tgt;
    logic [15:0] volt;
    logic [15:0] pha;
    logic [15:0] phb;
    logic phcur;
  } st_t;

endpackage

/* File: hdl/sincos_lut.sv */
// Purpose: sine and cosine of a 64-step commutation angle, scaled by an amplitude
// Assumes: combinational; the caller registers the results
// Notes: magnitude = amplitude * table / 512, table peak 255
module sincos_lut
  import setpoint_pkg::*;
(
  input wire logic [5:0] angle,
  input wire logic [15:0] amplitude,
  output logic signed [15:0] sin_out,
  output logic signed [15:0] cos_out
);

  function automatic logic [7:0] quarter(input logic [4:0] k);
    logic [7:0] t;
    t = 8'h00;
    case (k)
      5'd0: t = 8'h00;
      5'd1: t = 8'h19;
      5'd2: t = 8'h32;
      5'd3: t = 8'h4A;
      5'd4: t = 8'h62;
      5'd5: t = 8'h79;
      5'd6: t = 8'h8E;
      5'd7: t = 8'hA2;
      5'd8: t = 8'hB4;
      5'd9: t = 8'hC5;
      5'd10: t = 8'hD4;
      5'd11: t = 8'hE1;
      5'd12: t = 8'hEC;
      5'd13: t = 8'hF4;
      5'd14: t = 8'hFA;
      5'd15: t = 8'hFE;
      default: t = 8'hFF;
    endcase
    return t;
  endfunction

  function automatic logic signed [15:0] wave(input logic [5:0] a, input logic [15:0] amp);
    logic [7:0] t;
    logic [23:0] prod;
    t = a[4] ? quarter(5'd16 - {1'b0, a[3:0]}) : quarter({1'b0, a[3:0]});
    prod = amp * t;
    return a[5] ? -$signed({1'b0, prod[23:9]}) : $signed({1'b0, prod[23:9]});
  endfunction

  // cosine leads sine by a quarter period
  assign sin_out = wave(angle, amplitude);
  assign cos_out = wave(6'(angle + 6'd16), amplitude);

endmodule

/* File: hdl/setpoint_core.sv */
// Purpose: voltage-mode and external-position set-point selection with stepper commutation
// Assumes: zero-wait AHB-Lite slave; analog, pwm and actual position come from logic on CLK
// Notes: encoder and step pins pass a three-stage synchroniser with agreement filter

// Notes on behaviour
// R01: voltage mode drives proportional motor voltage, current limiting stays enabled.
// R02: with output stage enabled a new voltage set-point applies at once, 10 mV units.
// R03: mode object value -1 selects voltage mode.
// R04: voltage reference is signed 16 bits, read/write, reset 0, 10 mV per digit.
// R05: voltage source selector 0 means the voltage reference is the set-point.
// R06: source table: entry count 4 read-only, four 8-bit selectors resetting to 0.
// R07: mode object value -2 selects external-position mode.
// R08: analog or pwm source gives an absolute target applied directly.
// R09: quadrature or pulse/direction counts start at mode entry, giving relative travel.
// R10: analog, pwm, motor encoder and reference/pulse inputs each use their own scaling.
// R11: these modes give no special meaning to control or status word bits.
// R12: synchronous drive uses target position directly as the commutation angle.
// R13: internal resolution equals steps per revolution over 4 times interpolation rate.
// R14: constant-voltage drive outputs nominal voltage times sine and cosine.
// R15: constant-current drive sets phase currents of continuous-current amplitude.
// R16: reference/pulse input gain adapts set-point position resolution.
// R17: the external motion master must respect ramps and speed limits itself.
module setpoint_core
  import setpoint_pkg::*;
(
  input wire logic CLK,
  input wire logic ARST_N,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  input wire logic signed [15:0] FIRST_ANALOG_INPUT,
  input wire logic signed [15:0] SECOND_ANALOG_INPUT,
  input wire logic signed [15:0] PWM_INPUT,
  input wire logic signed [31:0] ACTUAL_POSITION,
  input wire logic REF_ENC_A,
  input wire logic REF_ENC_B,
  input wire logic MOT_ENC_A,
  input wire logic MOT_ENC_B,
  input wire logic STEP_PULSE,
  input wire logic STEP_DIR,
  output logic signed [15:0] VOLTAGE_CMD,
  output logic CURRENT_LIMIT_EN,
  output logic signed [31:0] POSITION_TARGET,
  output logic signed [15:0] PHASE_A,
  output logic signed [15:0] PHASE_B,
  output logic PHASE_IS_CURRENT,
  output logic OUTPUT_STAGE_EN,
  output logic [1:0] OP_MODE
);

  st_t r_reg;
  st_t r_next;
  logic take;
  logic stage_en;
  logic sync_on;
  logic [5:0] angle;
  logic signed [15:0] lut_sin;
  logic signed [15:0] lut_cos;
  logic signed [31:0] an1_scaled;
  logic signed [31:0] an2_scaled;
  logic signed [31:0] pwm_scaled;
  logic signed [31:0] rel_travel;
  logic signed [31:0] vsel;
  logic signed [31:0] pm;
  logic signed [31:0] interp_s;
  logic [31:0] resolution;

  function automatic logic signed [31:0] scale(input logic signed [31:0] v,
                                              input logic [15:0] gain);
    logic signed [49:0] prod;
    prod = v * $signed({1'b0, gain});
    return prod[31+GAIN_FRAC:GAIN_FRAC];
  endfunction

  function automatic logic signed [15:0] sat16(input logic signed [31:0] v);
    if (v > 32'sd32767)
    begin
      return 16'h7FFF;
    end
    if (v < -32'sd32768)
    begin
      return 16'h8000;
    end
    return v[15:0];
  endfunction

  // one gray step per sample; a double jump is dropped rather than guessed
  function automatic logic signed [31:0] qstep(input logic [1:0] o, input logic [1:0] c);
    case ({o, c})
      4'b0001, 4'b0111, 4'b1110, 4'b1000: return 32'sd1;
      4'b0010, 4'b1011, 4'b1101, 4'b0100: return -32'sd1;
      default: return 32'sd0;
    endcase
  endfunction

  function automatic logic [31:0] read_reg(input st_t s, input logic [25:0] a,
                                           input logic [31:0] res);
    case (a)
      ADDR_MODE: return {24'h000000, s.mode_obj};
      ADDR_SRC_COUNT: return {24'h000000, SRC_ENTRY_COUNT}; // R06
      ADDR_SRC_VOLT: return {24'h000000, s.src[0]};
      ADDR_SRC_CURR: return {24'h000000, s.src[1]};
      ADDR_SRC_VEL: return {24'h000000, s.src[2]};
      ADDR_SRC_POS: return {24'h000000, s.src[3]};
      ADDR_VREF: return {16'h0000, s.vref}; // R04
      ADDR_AN_GAIN: return {16'h0000, s.an_gain};
      ADDR_AN_OFF: return {16'h0000, s.an_off};
      ADDR_MOT_GAIN: return {16'h0000, s.mot_gain};
      ADDR_REF_GAIN: return {16'h0000, s.ref_gain};
      ADDR_PWM_GAIN: return {16'h0000, s.pwm_gain};
      ADDR_PWM_OFF: return {16'h0000, s.pwm_off};
      ADDR_STEPS: return {16'h0000, s.steps};
      ADDR_INTERP: return {16'h0000, s.interp};
      ADDR_CTRL: return {29'h00000000, s.ctrl};
      ADDR_VNOM: return {16'h0000, s.vnom};
      ADDR_ICONT: return {16'h0000, s.icont};
      ADDR_POS_TGT: return s.pos_tgt;
      ADDR_VOLT_OUT: return {16'h0000, s.volt};
      ADDR_RES: return res;
      ADDR_REL_CNT: return s.src[3] == SRC_MOT_QUAD ? s.cnt_mot : s.cnt_ref;
      default: return 32'h00000000;
    endcase
  endfunction

  sincos_lut u_lut (
    .angle(angle),
    .amplitude(r_reg.ctrl[2:1] == SYNC_CONST_I ? r_reg.icont : r_reg.vnom),
    .sin_out(lut_sin),
    .cos_out(lut_cos)
  );

  always_comb
  begin
    r_next = r_reg;
    take = HSEL & HTRANS[1] & HREADY;
    stage_en = r_reg.ctrl[0];
    // scaling per source family
    an1_scaled = scale(32'(FIRST_ANALOG_INPUT) + 32'(signed'(r_reg.an_off)), r_reg.an_gain); // R10
    an2_scaled = scale(32'(SECOND_ANALOG_INPUT) + 32'(signed'(r_reg.an_off)), r_reg.an_gain);
    pwm_scaled = scale(32'(PWM_INPUT) + 32'(signed'(r_reg.pwm_off)), r_reg.pwm_gain); // R10
    resolution = 32'((r_reg.steps >> RES_DIV_SHIFT) * r_reg.interp); // R13
    interp_s = $signed({16'h0000, r_reg.interp});
    pm = 32'sd0;
    angle = 6'h00;
    // commutation angle is the target taken modulo one sine period
    if (r_reg.interp != 16'h0000)
    begin
      pm = $signed(r_reg.pos_tgt) % interp_s; // R12
      if (pm < 0)
      begin
        pm = pm + interp_s;
      end
      angle = 6'((pm * ANGLE_STEPS) / interp_s); // R14
    end
    // data phase of a write
    if (r_reg.wr_pend)
    begin
      case (r_reg.addr)
        ADDR_MODE: r_next.mode_obj = HWDATA[7:0];
        ADDR_SRC_VOLT: r_next.src[0] = HWDATA[7:0]; // R06
        ADDR_SRC_CURR: r_next.src[1] = HWDATA[7:0];
        ADDR_SRC_VEL: r_next.src[2] = HWDATA[7:0];
        ADDR_SRC_POS: r_next.src[3] = HWDATA[7:0];
        ADDR_VREF: r_next.vref = HWDATA[15:0]; // R04
        ADDR_AN_GAIN: r_next.an_gain = HWDATA[15:0];
        ADDR_AN_OFF: r_next.an_off = HWDATA[15:0];
        ADDR_MOT_GAIN: r_next.mot_gain = HWDATA[15:0];
        ADDR_REF_GAIN: r_next.ref_gain = HWDATA[15:0]; // R16
        ADDR_PWM_GAIN: r_next.pwm_gain = HWDATA[15:0];
        ADDR_PWM_OFF: r_next.pwm_off = HWDATA[15:0];
        ADDR_STEPS: r_next.steps = HWDATA[15:0];
        ADDR_INTERP: r_next.interp = HWDATA[15:0];
        ADDR_CTRL: r_next.ctrl = HWDATA[2:0];
        ADDR_VNOM: r_next.vnom = HWDATA[15:0];
        ADDR_ICONT: r_next.icont = HWDATA[15:0];
        default: r_next.ctrl = r_next.ctrl;
      endcase
    end
    r_next.wr_pend = take & HWRITE;
    if (take)
    begin
      r_next.addr = HADDR[25:0];
    end
    // read sees a write still in its data phase
    if (take & ~HWRITE)
    begin
      r_next.hrdata = read_reg(r_next, HADDR[25:0], resolution);
    end
    // only the mode object steers the mode; control word bits play no part
    case (r_reg.mode_obj)
      MODE_VOLTAGE: r_next.ops = OPS_VOLT; // R03 R11
      MODE_EXT_POS: r_next.ops = OPS_EXTPOS; // R07
      default: r_next.ops = OPS_IDLE;
    endcase
    r_next.s1 = {STEP_DIR, STEP_PULSE, MOT_ENC_B, MOT_ENC_A, REF_ENC_B, REF_ENC_A};
    r_next.s2 = r_reg.s1;
    r_next.s3 = r_reg.s2;
    r_next.filt = (~(r_reg.s2 ^ r_reg.s3) & r_reg.s2) | ((r_reg.s2 ^ r_reg.s3) & r_reg.filt);
    // relative counts restart on entry so travel is measured from there
    if (r_next.ops == OPS_EXTPOS && r_reg.ops != OPS_EXTPOS)
    begin
      r_next.cnt_mot = 32'h00000000; // R09
      r_next.cnt_ref = 32'h00000000; // R09
      r_next.base_pos = ACTUAL_POSITION;
    end
    else
    begin
      r_next.cnt_mot = r_reg.cnt_mot + qstep(r_reg.filt[3:2], r_next.filt[3:2]);
      if (r_reg.src[3] == SRC_PULSE_DIR)
      begin
        if (r_next.filt[4] & ~r_reg.filt[4])
        begin
          r_next.cnt_ref = r_reg.cnt_ref + (r_next.filt[5] ? 32'sd1 : -32'sd1); // R09
        end
      end
      else
      begin
        r_next.cnt_ref = r_reg.cnt_ref + qstep(r_reg.filt[1:0], r_next.filt[1:0]);
      end
    end
    // voltage set-point selection
    case (r_reg.src[0])
      SRC_NONE: vsel = 32'(signed'(r_reg.vref)); // R05
      SRC_AN1: vsel = an1_scaled;
      SRC_AN2: vsel = an2_scaled;
      SRC_PWM: vsel = pwm_scaled;
      default: vsel = 32'sd0;
    endcase
    // unknown codes give no drive rather than a guess
    r_next.volt = (r_reg.ops == OPS_VOLT && stage_en) ? sat16(vsel) : 16'h0000; // R01 R02
    rel_travel = (r_reg.src[3] == SRC_MOT_QUAD) ? scale(r_reg.cnt_mot, r_reg.mot_gain) :
                 scale(r_reg.cnt_ref, r_reg.ref_gain); // R10 R16
    if (r_reg.ops == OPS_EXTPOS && stage_en)
    begin
      case (r_reg.src[3])
        SRC_AN1: r_next.pos_tgt = an1_scaled; // R08
        SRC_AN2: r_next.pos_tgt = an2_scaled; // R08
        SRC_PWM: r_next.pos_tgt = pwm_scaled; // R08
        SRC_MOT_QUAD, SRC_REF_QUAD, SRC_PULSE_DIR: r_next.pos_tgt = r_reg.base_pos + rel_travel;
        default: r_next.pos_tgt = r_reg.pos_tgt;
      endcase
    end
    // no speed or position loop here: ramps are the master's job
    sync_on = r_reg.ops == OPS_EXTPOS && stage_en && r_reg.ctrl[2:1] != SYNC_OFF; // R17
    r_next.pha = sync_on ? lut_sin : 16'h0000; // R12 R14
    r_next.phb = sync_on ? lut_cos : 16'h0000; // R14
    r_next.phcur = sync_on && r_reg.ctrl[2:1] == SYNC_CONST_I; // R15
  end

  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      r_reg <= '0;
      r_reg.an_gain <= GAIN_RESET;
      r_reg.pwm_gain <= GAIN_RESET;
      r_reg.mot_gain <= GAIN_RESET;
      r_reg.ref_gain <= GAIN_RESET;
      r_reg.interp <= INTERP_RESET;
      r_reg.steps <= STEPS_RESET;
    end
    else
    begin
      r_reg <= r_next;
    end
  end

  assign HRDATA = r_reg.hrdata;
  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;
  assign VOLTAGE_CMD = r_reg.volt;
  // current loop stays armed as a limiter in voltage mode
  assign CURRENT_LIMIT_EN = r_reg.ops != OPS_IDLE; // R01
  assign POSITION_TARGET = r_reg.pos_tgt;
  assign PHASE_A = r_reg.pha;
  assign PHASE_B = r_reg.phb;
  assign PHASE_IS_CURRENT = r_reg.phcur;
  assign OUTPUT_STAGE_EN = r_reg.ctrl[0];
  assign OP_MODE = r_reg.ops;

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!ARST_N);

  a_curlim_volt: assert property ((r_reg.ops == OPS_VOLT) |-> CURRENT_LIMIT_EN) // R01
    else $error("current limit off in voltage mode");
  a_volt_off: assert property (!(r_reg.ops == OPS_VOLT && r_reg.ctrl[0])
    |=> VOLTAGE_CMD == 16'h0000) // R02
    else $error("voltage driven while not enabled in voltage mode");
  a_mode_volt: assert property ((r_reg.wr_pend && r_reg.addr == ADDR_MODE
    && HWDATA[7:0] == MODE_VOLTAGE) |=> ##1 r_reg.ops == OPS_VOLT) // R03
    else $error("mode -1 did not select voltage mode");
  a_vref_follow: assert property ((r_reg.ops == OPS_VOLT && r_reg.ctrl[0] && r_reg.src[0] == 8'h00)
    |=> VOLTAGE_CMD == $past(r_reg.vref)) // R05
    else $error("voltage reference not applied");
  a_count_read: assert property ((take && !HWRITE && HADDR[25:0] == ADDR_SRC_COUNT)
    |=> HRDATA == 32'h00000004) // R06
    else $error("entry count not 4");
  a_mode_ext: assert property ((r_reg.wr_pend && r_reg.addr == ADDR_MODE
    && HWDATA[7:0] == MODE_EXT_POS) |=> ##1 r_reg.ops == OPS_EXTPOS) // R07
    else $error("mode -2 did not select external position mode");
  a_abs_analog: assert property ((r_reg.ops == OPS_EXTPOS && r_reg.ctrl[0]
    && r_reg.src[3] == SRC_AN1) |=> POSITION_TARGET == $past(an1_scaled)) // R08
    else $error("analog target not applied absolutely");
  a_entry_zero: assert property ($changed(r_reg.ops) && r_reg.ops == OPS_EXTPOS
    |-> r_reg.cnt_ref == 32'h0 && r_reg.cnt_mot == 32'h0 && r_reg.base_pos == $past(ACTUAL_POSITION)) // R09
    else $error("relative counts not restarted at entry");
  a_res_read: assert property ((take && !HWRITE && HADDR[25:0] == ADDR_RES)
    |=> HRDATA == 32'(($past(r_reg.steps) >> 2) * $past(r_reg.interp))) // R13
    else $error("internal resolution wrong");
  a_sync_off: assert property ((r_reg.ctrl[2:1] == SYNC_OFF || r_reg.ops != OPS_EXTPOS)
    |=> PHASE_A == 16'h0000 && PHASE_B == 16'h0000 && !PHASE_IS_CURRENT) // R12
    else $error("phases driven outside synchronous drive");
  a_const_cur: assert property ((r_reg.ops == OPS_EXTPOS && r_reg.ctrl == {SYNC_CONST_I, 1'b1})
    |=> PHASE_IS_CURRENT) // R15
    else $error("constant current drive not flagged");
  a_mode_hold: assert property ($stable(r_reg.mode_obj) |=> $stable(r_reg.ops)) // R11
    else $error("operating mode moved without a mode object write");
  a_volt_unknown: assert property ((r_reg.ops == OPS_VOLT && r_reg.src[0] > SRC_PWM) // R05
    |=> VOLTAGE_CMD == 16'h0000)
    else $error("unknown voltage source drives the motor");
  a_target_hold: assert property (!r_reg.ctrl[0] |=> $stable(POSITION_TARGET)) // R08
    else $error("position target moved with output stage off");

  c_volt_run: cover property (r_reg.ops == OPS_VOLT && r_reg.ctrl[0] && VOLTAGE_CMD != 16'h0000);
  c_ext_entry: cover property (r_reg.ops != OPS_EXTPOS ##1 r_reg.ops == OPS_EXTPOS);
  c_step_count: cover property (r_reg.ops == OPS_EXTPOS && r_reg.cnt_ref != 32'h0);
  c_sync_cur: cover property (PHASE_IS_CURRENT && PHASE_B != 16'h0000);
  c_volt_analog: cover property (r_reg.ops == OPS_VOLT && r_reg.src[0] == SRC_AN1
    && VOLTAGE_CMD != 16'h0000);

endmodule

/* File: tb/step_source.sv */
// Purpose: pulse/direction set-point source standing in for the motion master
// Assumes: each pin level held at least four clocks, well inside the synchroniser limits
// Notes: the master, not the block, keeps the step rate within the ramps
module step_source (
  input wire logic CLK,
  output logic STEP_PULSE,
  output logic STEP_DIR
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    STEP_PULSE = 1'b0;
    STEP_DIR = 1'b0;
  end
  task automatic burst(input int n, input logic dir);
    for (int i = 0; i < n; i++)
    begin
      STEP_DIR <= dir;
      // fixed slow rate: ramps and top speed are ours to respect
      repeat (4) @(posedge CLK);
      STEP_PULSE <= 1'b1;
      repeat (4) @(posedge CLK);
      STEP_PULSE <= 1'b0;
      repeat (4) @(posedge CLK);
    end
  endtask
endmodule

/* File: tb/tb_setpoint_core.sv */
// Purpose: self-checking bench for the set-point block over AHB-Lite
// Assumes: zero-wait slave, reads checked by a monitor against a queue
// Notes: both encoders share one driven pair; relative counts via pulse/direction and quadrature
module tb_setpoint_core
  import setpoint_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, arst_n, hsel, hwrite, hready, hreadyout, hresp, dph_rd;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic [1:0] htrans, op_mode, enc;
  logic [2:0] hsize;
  logic signed [15:0] an1, an2, pwm, volt_cmd, pha, phb, v;
  logic signed [15:0] raw[1:3];
  logic signed [31:0] act_pos, pos_tgt;
  logic step_pulse, step_dir, clim, ph_cur, stage_en;
  logic [31:0] expq[$];
  int failures, cmp_count;
  assign hready = hreadyout;
  setpoint_core dut (
    .CLK(clk), .ARST_N(arst_n), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata),
    .HREADYOUT(hreadyout), .HRESP(hresp), .FIRST_ANALOG_INPUT(an1),
    .SECOND_ANALOG_INPUT(an2), .PWM_INPUT(pwm), .ACTUAL_POSITION(act_pos),
    .REF_ENC_A(enc[0]), .REF_ENC_B(enc[1]), .MOT_ENC_A(enc[0]), .MOT_ENC_B(enc[1]),
    .STEP_PULSE(step_pulse), .STEP_DIR(step_dir), .VOLTAGE_CMD(volt_cmd),
    .CURRENT_LIMIT_EN(clim), .POSITION_TARGET(pos_tgt), .PHASE_A(pha), .PHASE_B(phb),
    .PHASE_IS_CURRENT(ph_cur), .OUTPUT_STAGE_EN(stage_en), .OP_MODE(op_mode)
  );
  step_source src (.CLK(clk), .STEP_PULSE(step_pulse), .STEP_DIR(step_dir));
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  // for reads d is the expected word, checked by the monitor in the data phase
  task automatic bus(input logic wr, input logic [25:0] a, input logic [31:0] d);
    @(posedge clk);
    if (!wr)
      expq.push_back(d);
    hsel <= 1'b1;
    haddr <= {6'h00, a};
    htrans <= 2'h2;
    hwrite <= wr;
    @(posedge clk);
    while (!hready)
      @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wr ? d : 32'h0;
    @(posedge clk);
    while (!hready)
      @(posedge clk);
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge clk)
  begin
    if (dph_rd && hready)
    begin
      check("hrdata", expq.pop_front(), hrdata);
      check("hresp", 32'h0, {31'h0, hresp});
    end
    dph_rd <= hsel && htrans[1] && !hwrite && hready;
  end
  initial
  begin
    #200000;
    failures++;
    close_out();
  end
  initial
  begin
    {hsel, hwrite, arst_n} = 3'h0;
    enc = 2'h0;
    {haddr, hwdata, act_pos} = 96'h0;
    {an1, an2, pwm} = 48'h0;
    htrans = 2'h0;
    hsize = 3'h2;
    failures = 0;
    cmp_count = 0;
    void'($urandom(32'heb94662f));
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    bus(0, ADDR_SRC_COUNT, 32'h4);
    bus(1, ADDR_SRC_COUNT, 32'hFF);
    bus(0, ADDR_SRC_COUNT, 32'h4);
    bus(0, ADDR_VREF, 32'h0);
    bus(0, ADDR_RES, 32'hC80);
    bus(0, 26'h3FFFFFC, 32'h0);
    for (int i = 0; i < 4; i++)
    begin
      bus(0, ADDR_SRC_VOLT + 26'(4 * i), 32'h0);
      r = {24'h0, 8'($urandom)};
      bus(1, ADDR_SRC_VOLT + 26'(4 * i), r);
      bus(0, ADDR_SRC_VOLT + 26'(4 * i), r);
      bus(1, ADDR_SRC_VOLT + 26'(4 * i), 32'h0);
    end
    $display("test registers done");
    v = 16'($urandom);
    bus(1, ADDR_CTRL, 32'h1);
    bus(1, ADDR_VREF, {16'h0, v});
    bus(1, ADDR_MODE, 32'hFF);
    settle(2);
    check("op_mode", 32'h1, {30'h0, op_mode});
    check("current_limit", 32'h1, {31'h0, clim});
    check("stage_enable", 32'h1, {31'h0, stage_en});
    check("voltage_cmd", 32'(v), 32'(volt_cmd));
    bus(0, ADDR_VREF, {16'h0, v});
    bus(1, ADDR_VREF, 32'h8000);
    settle(1);
    check("voltage_cmd", 32'hFFFF8000, 32'(volt_cmd));
    bus(1, ADDR_SRC_VOLT, 32'h7);
    settle(1);
    check("voltage_cmd", 32'h0, 32'(volt_cmd));
    an1 <= 16'sd300;
    bus(1, ADDR_SRC_VOLT, 32'h1);
    settle(1);
    check("voltage_cmd", 32'd300, 32'(volt_cmd));
    bus(1, ADDR_SRC_VOLT, 32'h0);
    bus(1, ADDR_CTRL, 32'h0);
    settle(1);
    check("voltage_cmd", 32'h0, 32'(volt_cmd));
    $display("test voltage mode done");
    bus(1, ADDR_CTRL, 32'h1);
    bus(1, ADDR_MODE, 32'hFE);
    for (int s = 1; s < 4; s++)
      raw[s] = 16'($urandom_range(16000));
    an1 <= raw[1];
    an2 <= raw[2];
    pwm <= raw[3];
    settle(1);
    check("op_mode", 32'h3, {30'h0, op_mode});
    for (int s = 1; s < 4; s++)
    begin
      bus(1, ADDR_SRC_POS, 32'(s));
      settle(2);
      check("position_target", 32'(raw[s]), 32'(pos_tgt));
    end
    bus(1, ADDR_SRC_POS, 32'h1);
    bus(1, ADDR_AN_OFF, 32'h10);
    bus(1, ADDR_AN_GAIN, 32'h200);
    settle(2);
    check("position_target", 32'(raw[1]) * 2 + 32'h20, 32'(pos_tgt));
    bus(0, ADDR_POS_TGT, 32'(raw[1]) * 2 + 32'h20);
    bus(1, ADDR_AN_OFF, 32'h0);
    bus(1, ADDR_AN_GAIN, 32'h100);
    bus(1, ADDR_VNOM, 32'h100);
    bus(1, ADDR_ICONT, 32'h80);
    for (int c = 1; c < 3; c++)
    begin
      bus(1, ADDR_CTRL, 32'(2 * c + 1));
      // quarter period: cosine term is zero
      an1 <= 16'(64 * $urandom_range(200) + 16);
      settle(3);
      check("phase_b", 32'h0, 32'(phb));
      check("phase_current", 32'(c - 1), {31'h0, ph_cur});
      check("phase_a", c == 1 ? 32'h7F : 32'h3F, 32'(pha));
      @(posedge clk);
      an1 <= 16'(64 * $urandom_range(200));
      settle(3);
      check("phase_a", 32'h0, 32'(pha));
    end
    $display("test analog position and stepper done");
    bus(1, ADDR_CTRL, 32'h1);
    bus(1, ADDR_MODE, 32'h0);
    r = 32'($urandom_range(100000));
    act_pos <= r;
    bus(1, ADDR_SRC_POS, 32'h9);
    bus(1, ADDR_REF_GAIN, 32'h200);
    bus(1, ADDR_MODE, 32'hFE);
    // base is captured at the entry edge; move only after it
    repeat (2) @(posedge clk);
    // later motion of the actual position must not move the base
    act_pos <= r + 32'h3E8;
    src.burst(7, 1'b1);
    src.burst(3, 1'b0);
    settle(8);
    check("position_target", r + 32'h8, 32'(pos_tgt));
    bus(0, ADDR_REL_CNT, 32'h4);
    bus(1, ADDR_SRC_POS, 32'h4);
    // six gray steps forward; the ref count adds them to its four pulses
    repeat (6)
    begin
      enc <= {enc[0], ~enc[1]};
      repeat (4) @(posedge clk);
    end
    settle(8);
    check("position_target", r + 32'h6, 32'(pos_tgt));
    bus(0, ADDR_REL_CNT, 32'h6);
    bus(1, ADDR_SRC_POS, 32'h5);
    settle(2);
    check("position_target", r + 32'h14, 32'(pos_tgt));
    $display("test pulse direction done");
    close_out();
  end
endmodule
